// [hw/adcsr_sync.sv]
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_in.
module adcsr_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : adcsr_sync

// [hw/adcsr_top.sv]
// Serial result readout of a 16-bit sampling converter: chip-select and chain modes.
// Assumes convert, select and serial clock come from pins; sample_data_in is on the core clock.
`include "adcsr_cfg.svh"

// Function
// R1 - Select high at convert rise: chip-select, Hi-Z
// R2 - Three-wire busy: Hi-Z until conversion ends
// R3 - Host returns convert low before minimum time
// R4 - Busy enabled: output driven low at completion
// R5 - After conversion: acquisition then standby
// R6 - Busy modes: MSB first, falling edges advance
// R7 - Bit stays valid across both clock edges
// R8 - Three-wire busy: release at 17th or convert
// R9 - Host keeps output contention short
// R10 - Four-wire: host holds convert high throughout
// R11 - Select and convert low: drive output low
// R12 - Four-wire no busy: host holds select high
// R13 - Four-wire plain: select low shows MSB
// R14 - Four-wire plain: release at 16th or select
// R15 - Four-wire busy: host holds select low
// R16 - Four-wire busy: release at 17th or select
// R17 - Clock low at convert rise: chain, no busy
// R18 - Chain plain: MSB appears at conversion end
// R19 - Chain: select level shifts in on falls
// R20 - Host gives sixteen clocks per chained device
// R21 - Chain: host holds convert high throughout
// R22 - Convert rise latches select: mode choice
// R23 - Chip-select: busy if either pin low
// R24 - Chain: clock high at rise enables busy
// R25 - Conversion time lies between configurable bounds
module adcsr_top #(
    parameter int DATA_W = `ADCSR_DATA_W,
    parameter int TCONV_CYC = `ADCSR_TCONV_CYC
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Serial pins from the host
    input wire logic convert_start_in,
    input wire logic serial_in_select_in,
    input wire logic sclk_in,
    // Converter result
    input wire adcsr_pkg::adcsr_word_t sample_data_in,
    // Serial result pin
    output logic serial_result_data_out,
    output logic serial_result_oe_n_out,
    // Status
    output logic conv_busy_out,
    output logic chain_mode_out,
    output logic busy_ind_out
);
    import adcsr_pkg::*;

    localparam int SH_W = DATA_W + 1;
    localparam int TC_MIN_A = `ADCSR_TCONV_MIN_CYC;
    localparam int TC_MAX_A = `ADCSR_TCONV_MAX_CYC;
    localparam logic [`ADCSR_TMR_W-1:0] TCONV_LD = TCONV_CYC[`ADCSR_TMR_W-1:0];
    localparam logic [`ADCSR_TMR_W-1:0] TMR_ONE = `ADCSR_TMR_W'(1);

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic cnv_s;
    logic sdi_s;
    logic sck_s;
    logic cnv_d_r;
    logic sdi_d_r;
    logic sck_d_r;
    logic cnv_rise;
    logic cnv_fall;
    logic sdi_rise;
    logic sck_fall;

    adcsr_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .async_in({convert_start_in, serial_in_select_in, sclk_in}),
        .sync_out(pins_s)
    );

    assign cnv_s = pins_s[2];
    assign sdi_s = pins_s[1];
    assign sck_s = pins_s[0];

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            cnv_d_r <= 1'b0;
            sdi_d_r <= 1'b0;
            sck_d_r <= 1'b0;
        end else begin
            cnv_d_r <= cnv_s;
            sdi_d_r <= sdi_s;
            sck_d_r <= sck_s;
        end
    end

    assign cnv_rise = cnv_s & ~cnv_d_r;
    assign cnv_fall = ~cnv_s & cnv_d_r;
    assign sdi_rise = sdi_s & ~sdi_d_r;
    assign sck_fall = ~sck_s & sck_d_r;

    // ----------------------------------------------------------------
    // Readout sequencer
    // ----------------------------------------------------------------
    adcsr_state_t state_r;
    adcsr_state_t state_nxt;
    logic [`ADCSR_TMR_W-1:0] tmr_r;
    logic [`ADCSR_TMR_W-1:0] tmr_nxt;
    logic [`ADCSR_CNT_W-1:0] cnt_r;
    logic [`ADCSR_CNT_W-1:0] cnt_nxt;
    logic [SH_W-1:0] sh_r;
    logic [SH_W-1:0] sh_nxt;
    logic chain_r;
    logic chain_nxt;
    logic busy_r;
    logic busy_nxt;
    logic sdo_nxt;
    logic oe_n_nxt;
    logic conv_end;
    logic start;

    assign conv_end = (state_r == ADCSR_CONV) && (tmr_r == TMR_ONE);
    // A running conversion ignores the convert pin until it ends.
    assign start = cnv_rise && (state_r != ADCSR_CONV);

    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        chain_nxt = chain_r;
        busy_nxt = busy_r;
        if (start) begin
            state_nxt = ADCSR_CONV;
            tmr_nxt = TCONV_LD;
            cnt_nxt = '0;
            chain_nxt = ~sdi_s; // R22
            busy_nxt = ~sdi_s & sck_s; // R17 R24
        end else begin
            case (state_r)
                ADCSR_IDLE: begin
                end
                ADCSR_CONV: begin
                    tmr_nxt = tmr_r - TMR_ONE; // R25
                    if (conv_end) begin
                        if (chain_r) begin
                            state_nxt = ADCSR_SHIFT; // R18
                            sh_nxt = busy_r ? {1'b1, sample_data_in} : {sample_data_in, 1'b0};
                        end else if (~cnv_s | ~sdi_s) begin
                            busy_nxt = 1'b1; // R23
                            state_nxt = ADCSR_SHIFT; // R4 R5
                            sh_nxt = {1'b0, sample_data_in};
                        end else begin
                            busy_nxt = 1'b0;
                            state_nxt = ADCSR_WAIT; // R5
                            sh_nxt = {sample_data_in, 1'b0};
                        end
                    end
                end
                ADCSR_WAIT: begin
                    if (~cnv_s | ~sdi_s) begin
                        state_nxt = ADCSR_SHIFT; // R13
                    end
                end
                ADCSR_SHIFT: begin
                    if (chain_r) begin
                        if (cnv_fall) begin
                            state_nxt = ADCSR_IDLE;
                        end else if (sck_fall) begin
                            // A plain chain word has no start bit, so upstream data enters ahead of the pad bit, which stays last.
                            if (busy_r) begin
                                sh_nxt = {sh_r[SH_W-2:0], sdi_s}; // R19
                            end else begin
                                sh_nxt = {sh_r[SH_W-2:1], sdi_s, 1'b0}; // R19
                            end
                        end
                    end else if (sdi_rise) begin
                        state_nxt = ADCSR_DONE; // R14 R16
                    end else if (sck_fall) begin
                        sh_nxt = {sh_r[SH_W-2:0], 1'b0}; // R6 R7
                        cnt_nxt = cnt_r + `ADCSR_CNT_W'(1);
                        if (cnt_nxt == (busy_r ? `ADCSR_BITS_BUSY : `ADCSR_BITS_PLAIN)) begin
                            state_nxt = ADCSR_DONE; // R8 R14 R16
                        end
                    end
                end
                ADCSR_DONE: begin
                end
                default: begin
                    state_nxt = ADCSR_IDLE;
                end
            endcase
        end
        sdo_nxt = 1'b0;
        oe_n_nxt = 1'b1; // R1 R2
        case (state_nxt)
            ADCSR_SHIFT: begin
                sdo_nxt = sh_nxt[SH_W-1];
                oe_n_nxt = 1'b0;
            end
            ADCSR_CONV: begin
                oe_n_nxt = ~chain_nxt;
            end
            ADCSR_IDLE, ADCSR_DONE: begin
                oe_n_nxt = cnv_s | sdi_s; // R11
            end
            default: begin
                oe_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_r <= ADCSR_IDLE;
            tmr_r <= '0;
            cnt_r <= '0;
            sh_r <= '0;
            chain_r <= 1'b0;
            busy_r <= 1'b0;
            serial_result_data_out <= 1'b0;
            serial_result_oe_n_out <= 1'b1;
            conv_busy_out <= 1'b0;
            chain_mode_out <= 1'b0;
            busy_ind_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            chain_r <= chain_nxt;
            busy_r <= busy_nxt;
            serial_result_data_out <= sdo_nxt;
            serial_result_oe_n_out <= oe_n_nxt;
            conv_busy_out <= (state_nxt == ADCSR_CONV);
            chain_mode_out <= chain_nxt;
            busy_ind_out <= busy_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);

    start_hiz_a: assert property (start && sdi_s |=> serial_result_oe_n_out && conv_busy_out) // R1
        else $error("Chip-select start did not float the output.");

    conv_float_a: assert property ((state_r == ADCSR_CONV) && !chain_r |-> serial_result_oe_n_out) // R2
        else $error("Output driven during chip-select conversion.");

    busy_low_a: assert property (conv_end && !chain_r && (!cnv_s || !sdi_s) && !start // R4
        |=> !serial_result_oe_n_out && !serial_result_data_out && busy_ind_out)
        else $error("Busy start bit not driven low at conversion end.");

    conv_len_a: assert property ($rose(state_r == ADCSR_CONV) // R25
        |-> ##[TC_MIN_A:TC_MAX_A] $fell(state_r == ADCSR_CONV))
        else $error("Conversion time outside its bounds.");

    busy_rel_a: assert property ((state_r == ADCSR_SHIFT) && !chain_r && busy_r && sck_fall // R8
        && (cnt_r == 5'h10) && !start && !sdi_rise |=> serial_result_oe_n_out && (state_r == ADCSR_DONE))
        else $error("Output not released at the 17th falling edge.");

    plain_rel_a: assert property ((state_r == ADCSR_SHIFT) && !chain_r && !busy_r && sck_fall // R14
        && (cnt_r == 5'h0F) && !start && !sdi_rise |=> serial_result_oe_n_out)
        else $error("Output not released at the 16th falling edge.");

    sel_rel_a: assert property ((state_r == ADCSR_SHIFT) && !chain_r && sdi_rise && !start // R16
        |=> serial_result_oe_n_out)
        else $error("Output not released on select rise.");

    plain_msb_a: assert property ((state_r == ADCSR_WAIT) && (!cnv_s || !sdi_s) && !start // R13
        |=> !serial_result_oe_n_out && (serial_result_data_out == $past(sh_r[SH_W-1])))
        else $error("Plain readout did not show the MSB on select.");

    both_low_a: assert property ((state_r == ADCSR_IDLE) && !cnv_s && !sdi_s // R11
        |=> !serial_result_oe_n_out && !serial_result_data_out)
        else $error("Output not driven low with both pins low.");

    chain_msb_a: assert property (conv_end && chain_r && !busy_r && !start // R18
        |=> !serial_result_oe_n_out && (serial_result_data_out == $past(sample_data_in[DATA_W-1])))
        else $error("Chain MSB not shown at conversion end.");

    bit_hold_a: assert property ((state_r == ADCSR_SHIFT) && (state_nxt == ADCSR_SHIFT) && !sck_fall // R7
        |=> $stable(serial_result_data_out))
        else $error("Output bit changed without a falling clock edge.");

    chain_in_a: assert property ((state_r == ADCSR_SHIFT) && chain_r && sck_fall && !cnv_fall && !start // R19
        |=> (busy_r ? sh_r[0] : sh_r[1]) == $past(sdi_s))
        else $error("Select level not shifted in on chain falling edge.");

    mode_latch_a: assert property (start |=> chain_r == !$past(sdi_s)) // R22
        else $error("Mode not latched from select at convert rise.");

    cs_busy_c: cover property (conv_end && !chain_r && !sdi_s);
    cs_plain_c: cover property ((state_r == ADCSR_WAIT) ##[1:1000] (state_r == ADCSR_DONE));
    cs_wire3_c: cover property ((state_r == ADCSR_WAIT) && !cnv_s && sdi_s);
    chain_c: cover property (conv_end && chain_r && !busy_r);
    chain_busy_c: cover property (conv_end && chain_r && busy_r);

endmodule : adcsr_top

// [include/adcsr_cfg.svh]
// Timing and layout constants of the serial result readout.
// Assumes a 250 MHz core clock; included by the package and the design.
`ifndef ADCSR_CFG_SVH
`define ADCSR_CFG_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define ADCSR_DATA_W 16
`define ADCSR_CNT_W 5
`define ADCSR_BITS_PLAIN 5'h10
`define ADCSR_BITS_BUSY 5'h11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCSR_CLK_MHZ 250
`define ADCSR_TCONV_MIN_NS 500
`define ADCSR_TCONV_MAX_NS 710
`define ADCSR_TCONV_NS 600
`define ADCSR_TCONV_CYC ((`ADCSR_TCONV_NS * `ADCSR_CLK_MHZ + 999) / 1000)
`define ADCSR_TCONV_MIN_CYC ((`ADCSR_TCONV_MIN_NS * `ADCSR_CLK_MHZ + 999) / 1000)
`define ADCSR_TCONV_MAX_CYC ((`ADCSR_TCONV_MAX_NS * `ADCSR_CLK_MHZ) / 1000)
`define ADCSR_TMR_W 10

`endif

// [include/adcsr_pkg.sv]
// Types shared by the serial result readout design.
// Assumes adcsr_cfg.svh is on the include path.
`include "adcsr_cfg.svh"

package adcsr_pkg;

    // ----------------------------------------------------------------
    // Readout sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ADCSR_IDLE,
        ADCSR_CONV,
        ADCSR_WAIT,
        ADCSR_SHIFT,
        ADCSR_DONE
    } adcsr_state_t;

    typedef logic [`ADCSR_DATA_W-1:0] adcsr_word_t;

endpackage : adcsr_pkg

// [testbench/adcsr_host_model.sv]
// Host model: drives convert, select and serial clock pins, resolves the result line.
// Assumes the core clock paces it; the result line carries a pull-up.
module adcsr_host_model (
    // Clock
    input wire logic core_clk_in,
    // Result pin from the device
    input wire logic serial_result_data_in,
    input wire logic serial_result_oe_n_in,
    // Pins to the device and the resolved line
    output logic convert_start_out,
    output logic serial_in_select_out,
    output logic sclk_out,
    output logic result_line_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Only one device shares the line, so there is no contention; a released line rises.
    assign result_line_out = serial_result_oe_n_in ? 1'b1 : serial_result_data_in;

    initial begin
        convert_start_out = 1'b0;
        serial_in_select_out = 1'b0;
        sclk_out = 1'b0;
    end

    task automatic pins(input logic convert_start, input logic sel, input logic sck);
        @(posedge core_clk_in);
        convert_start_out <= convert_start;
        serial_in_select_out <= sel;
        sclk_out <= sck;
    endtask : pins

    // Strap, rise, a short early window, then the conversion levels, set and left for the caller to hold.
    task automatic convert(input logic sel0, input logic sck0, input logic cnv_c, input logic sel_c);
        pins(1'b0, sel0, sck0);
        repeat (8) @(posedge core_clk_in);
        pins(1'b1, sel0, sck0);
        repeat (20) @(posedge core_clk_in);
        pins(cnv_c, sel_c, 1'b0);
    endtask : convert

    // One serial clock period of 40 core cycles; the bit is sampled in both halves.
    task automatic clock_bit(input logic sel, output logic b_lo, output logic b_hi);
        @(negedge core_clk_in);
        b_lo = result_line_out;
        pins(convert_start_out, sel, 1'b1);
        repeat (19) @(posedge core_clk_in);
        @(negedge core_clk_in);
        b_hi = result_line_out;
        pins(convert_start_out, sel, 1'b0);
        repeat (19) @(posedge core_clk_in);
    endtask : clock_bit
endmodule : adcsr_host_model

// [testbench/testbench.sv]
// Self-checking bench of the serial result readout: mode table, aborts, reset.
// Assumes the package and design are compiled first; the host model drives the pins.
`include "adcsr_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import adcsr_pkg::*;

    typedef struct {
        logic sel0, sck0, cnv_c, sel_c, cnv_r, sel_r, chain, busy;
        adcsr_word_t d;
        adcsr_word_t up;
    } adcsr_row_t;

    // Columns: strap select and clock, levels during conversion, levels for readback,
    // expected mode and busy indicator, result word and upstream word.
    adcsr_row_t rows [6] = '{
        '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 16'hA5C3, 16'h0000},
        '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h8001, 16'h0000},
        '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h7FFE, 16'h0000},
        '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h3C5A, 16'h0000},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h1234, 16'hF00F},
        '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0F0F, 16'hB6D9}
    };

    logic core_clk;
    logic resetn;
    adcsr_word_t sample_data;
    logic convert_start;
    logic sel;
    logic sck;
    logic res_data;
    logic res_oe_n;
    logic conv_busy;
    logic chain_mode;
    logic busy_ind;
    logic line;
    logic b_lo;
    logic b_hi;
    logic [32:0] exp_bits;
    int miscompares = 0;
    int checks_done = 0;

    adcsr_top dut_u (
        .core_clk_in(core_clk),
        .resetn_in(resetn),
        .convert_start_in(convert_start),
        .serial_in_select_in(sel),
        .sclk_in(sck),
        .sample_data_in(sample_data),
        .serial_result_data_out(res_data),
        .serial_result_oe_n_out(res_oe_n),
        .conv_busy_out(conv_busy),
        .chain_mode_out(chain_mode),
        .busy_ind_out(busy_ind)
    );

    adcsr_host_model host_u (
        .core_clk_in(core_clk),
        .serial_result_data_in(res_data),
        .serial_result_oe_n_in(res_oe_n),
        .convert_start_out(convert_start),
        .serial_in_select_out(sel),
        .sclk_out(sck),
        .result_line_out(line)
    );

    task automatic check(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %b seen %b", what, exp, got);
            miscompares++;
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic do_reset();
        host_u.pins(1'b0, 1'b0, 1'b0);
        resetn <= 1'b0;
        repeat (20) @(negedge core_clk);
        check("oe_n in reset", 1'b1, res_oe_n);
        check("busy in reset", 1'b0, conv_busy);
        check("chain in reset", 1'b0, chain_mode);
        @(posedge core_clk);
        resetn <= 1'b1;
        repeat (8) @(negedge core_clk);
        check("idle oe_n", 1'b0, res_oe_n);
        check("idle data", 1'b0, res_data);
    endtask : do_reset

    task automatic run_row(input adcsr_row_t rw);
        int n;
        logic s;
        n = (rw.busy ? 17 : 16) + (rw.chain ? 16 : 0);
        exp_bits = rw.busy ? {rw.chain, rw.d, rw.up} : {rw.d, rw.up, 1'b0};
        @(posedge core_clk);
        sample_data <= rw.d;
        host_u.convert(rw.sel0, rw.sck0, rw.cnv_c, rw.sel_c);
        repeat (90) @(negedge core_clk);
        check("busy mid", 1'b1, conv_busy);
        check("oe_n mid", ~rw.chain, res_oe_n);
        repeat (`ADCSR_TCONV_CYC) @(negedge core_clk);
        check("busy end", 1'b0, conv_busy);
        check("chain", rw.chain, chain_mode);
        check("busy ind", rw.busy, busy_ind);
        check("oe_n end", ~(rw.chain | rw.busy), res_oe_n);
        host_u.pins(rw.cnv_r, rw.sel_r, 1'b0);
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            s = rw.chain ? (i < 16 ? rw.up[15 - i] : 1'b0) : rw.sel_r;
            host_u.clock_bit(s, b_lo, b_hi);
            check("bit low", exp_bits[32 - i], b_lo);
            check("bit high", exp_bits[32 - i], b_hi);
        end
        @(negedge core_clk);
        if (rw.chain) begin
            host_u.pins(1'b0, 1'b0, 1'b0);
            repeat (8) @(negedge core_clk);
            check("oe_n chain end", 1'b0, res_oe_n);
            check("data chain end", 1'b0, res_data);
        end else begin
            check("oe_n released", 1'b1, res_oe_n);
        end
    endtask : run_row

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        conclude();
    end

    initial begin
        resetn = 1'b0;
        sample_data = 16'h0000;
        do_reset();
        foreach (rows[r]) begin
            run_row(rows[r]);
        end
        // Four-wire busy read cut by a select rise, then three-wire busy cut by a convert rise.
        for (int m = 1; m >= 0; m--) begin
            host_u.convert(1'b1, 1'b0, m[0], ~m[0]);
            repeat (`ADCSR_TCONV_CYC + 20) @(posedge core_clk);
            repeat (4) host_u.clock_bit(~m[0], b_lo, b_hi);
            host_u.pins(1'b1, 1'b1, 1'b0);
            repeat (6) @(negedge core_clk);
            check("oe_n abort", 1'b1, res_oe_n);
            check("busy restart", ~m[0], conv_busy);
        end
        // Second reset lands in mid-conversion.
        do_reset();
        conclude();
    end
endmodule : testbench
